// File: spm_defines.svh
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH

// Register indexes as printed; byte address is four times the index
`define SPM_IDX_CMD 16'h1811
`define SPM_IDX_WR_VAL 16'h1812
`define SPM_IDX_RD_VAL 16'h1813
`define SPM_IDX_CMD_STS 16'h1814
`define SPM_IDX_GLB_CFG 16'h1840
`define SPM_ADDR_CMD 16'h6044
`define SPM_ADDR_WR_VAL 16'h6048
`define SPM_ADDR_RD_VAL 16'h604C
`define SPM_ADDR_CMD_STS 16'h6050
`define SPM_ADDR_GLB_CFG 16'h6100

// Field positions
`define SPM_CMD_RNW_BIT 7
`define SPM_GLB_MLD_OTHER_NH 17
`define SPM_GLB_MLD_ANY_HBH 16
`define SPM_GLB_VID_IGNORE 15
`define SPM_GLB_USE_TAG 14
`define SPM_GLB_MON_ECHO 13
`define SPM_GLB_MON_PORT_HI 12
`define SPM_GLB_MON_PORT_LO 10
`define SPM_GLB_USE_IP 9
`define SPM_GLB_MLD_EN 8
`define SPM_GLB_IGMP_EN 7
`define SPM_GLB_CNT_TEST 6
`define SPM_GLB_DA_PRIO 5
`define SPM_GLB_FILT_MCAST 4
`define SPM_GLB_DROP_UNK 3
`define SPM_GLB_USE_PREC 2
`define SPM_GLB_TAG_OVER_IP 1
`define SPM_GLB_VLAN_EN 0

// Reset values and counter test load value
`define SPM_GLB_RESET 18'h00006
`define SPM_WR_VAL_RESET 3'h0
`define SPM_CNT_TEST_VALUE 32'h7FFFFFFC

// Table access latency in cycles
`define SPM_ACCESS_CYCLES 2

`endif

// File: spm_pkg.sv
package spm_pkg;

	typedef struct packed {
		logic mld_other_nh;
		logic mld_any_hbh;
		logic vid_ignore;
		logic use_tag;
		logic mon_echo;
		logic [2:0] mon_ports;
		logic use_ip;
		logic mld_en;
		logic igmp_en;
		logic cnt_test;
		logic da_prio;
		logic filt_mcast;
		logic drop_unknown;
		logic use_prec;
		logic tag_over_ip;
		logic vlan_en;
	} spm_glb_cfg_t;

	typedef struct packed {
		logic [5:0] idx;
		logic [2:0] prio;
	} spm_map_lookup_t;

	typedef enum logic [2:0] {
		SPM_IDLE = 3'b001,
		SPM_BUSY = 3'b010,
		SPM_DONE = 3'b100
	} spm_state_t;

endpackage : spm_pkg

// File: spm_map_ram.sv
`timescale 1ns/100ps
`default_nettype none

module spm_map_ram #(
	parameter int DEPTH = 64,
	parameter int WIDTH = 3,
	parameter int AW = 6
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);

	// No reset: contents undefined until written
	logic [WIDTH-1:0] mem [DEPTH];

	initial begin
		if (DEPTH > (1 << AW))
			$error("spm_map_ram: DEPTH exceeds address range");
	end

	always_ff @(posedge clk) begin
		if (we)
			mem[waddr] <= wdata;
		rdata <= mem[raddr];
	end

endmodule : spm_map_ram

`default_nettype wire

// File: spm_regs.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "spm_defines.svh"


module spm_regs #(
	parameter int TBL_DEPTH = 64,
	parameter int IDX_W = 6,
	parameter int PRIO_W = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output spm_pkg::spm_glb_cfg_t glb_cfg,
	input wire logic [IDX_W-1:0] tos_idx,
	output logic [PRIO_W-1:0] tos_prio,
	output logic [31:0] cnt_read_load
);
	import spm_pkg::*;

	initial begin
		if (TBL_DEPTH != (1 << IDX_W) || PRIO_W != 3)
			$error("spm_regs: unsupported table geometry");
	end

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire logic setup_ph = psel && !penable;
	wire logic hit_cmd = paddr == `SPM_ADDR_CMD;
	wire logic hit_wr = paddr == `SPM_ADDR_WR_VAL;
	wire logic hit_rd = paddr == `SPM_ADDR_RD_VAL;
	wire logic hit_sts = paddr == `SPM_ADDR_CMD_STS;
	wire logic hit_glb = paddr == `SPM_ADDR_GLB_CFG;
	wire logic hit_any = hit_cmd || hit_wr || hit_rd || hit_sts || hit_glb;
	// Access completes in the first access cycle
	wire logic do_acc = psel && penable;
	wire logic do_wr = do_acc && pwrite;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	spm_glb_cfg_t glb_q;
	logic [PRIO_W-1:0] wr_val_q;
	logic [PRIO_W-1:0] rd_val_q;
	logic cmd_rnw_q;
	logic [IDX_W-1:0] cmd_idx_q;
	spm_state_t state_q;
	spm_state_t state_d;
	logic [1:0] cnt_q;
	logic pending_q;
	logic [31:0] prdata_q;
	logic pslverr_q;

	wire logic launch = do_wr && hit_cmd && state_q == SPM_IDLE;
	wire logic [31:0] glb_word = {14'h0, glb_q};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			glb_q <= spm_glb_cfg_t'(`SPM_GLB_RESET);
			wr_val_q <= `SPM_WR_VAL_RESET;
			cmd_rnw_q <= 1'b0;
			cmd_idx_q <= '0;
		end else begin
			if (do_wr && hit_glb)
				glb_q <= spm_glb_cfg_t'(pwdata[17:0]);
			if (do_wr && hit_wr)
				wr_val_q <= pwdata[PRIO_W-1:0];
			if (launch) begin
				cmd_rnw_q <= pwdata[`SPM_CMD_RNW_BIT];
				cmd_idx_q <= pwdata[IDX_W-1:0];
			end
		end
	end

	// ----------------------------------------
	// Table access sequencer
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			SPM_IDLE: begin
				if (launch)
					state_d = SPM_BUSY;
			end
			SPM_BUSY: begin
				if (cnt_q == 2'(`SPM_ACCESS_CYCLES - 1))
					state_d = SPM_DONE;
			end
			SPM_DONE: state_d = SPM_IDLE;
			default: state_d = SPM_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= SPM_IDLE;
			cnt_q <= 2'h0;
			pending_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= (state_q == SPM_BUSY) ? cnt_q + 2'h1 : 2'h0;
			pending_q <= state_d != SPM_IDLE;
		end
	end

	// Table port shared between host access and lookup
	wire logic tbl_we = state_q == SPM_DONE && !cmd_rnw_q;
	wire logic [IDX_W-1:0] tbl_raddr = (state_q != SPM_IDLE) ? cmd_idx_q
		: tos_idx;
	logic [PRIO_W-1:0] tbl_rdata;

	spm_map_ram #(
		.DEPTH(TBL_DEPTH),
		.WIDTH(PRIO_W),
		.AW(IDX_W)
	) i_spm_map_ram (
		.clk(pclk),
		.we(tbl_we),
		.waddr(cmd_idx_q),
		.wdata(wr_val_q),
		.raddr(tbl_raddr),
		.rdata(tbl_rdata)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rd_val_q <= '0;
		else if (state_q == SPM_DONE && cmd_rnw_q)
			rd_val_q <= tbl_rdata;
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	wire logic [31:0] rd_mux =
		hit_glb ? glb_word :
		hit_wr ? {29'h0, wr_val_q} :
		hit_rd ? {29'h0, rd_val_q} :
		hit_sts ? {31'h0, pending_q} :
		hit_cmd ? {24'h0, cmd_rnw_q, 1'b0, cmd_idx_q} : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
			pslverr_q <= 1'b0;
		end else if (setup_ph) begin
			prdata_q <= pwrite ? 32'h0 : rd_mux;
			pslverr_q <= !hit_any;
		end
	end

	// ----------------------------------------
	// Outputs toward the switch engine
	// ----------------------------------------
	logic [PRIO_W-1:0] tos_prio_q;
	logic [31:0] cnt_load_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tos_prio_q <= '0;
			cnt_load_q <= 32'h0;
		end else begin
			tos_prio_q <= tbl_rdata;
			cnt_load_q <= glb_q.cnt_test ? `SPM_CNT_TEST_VALUE : 32'h0;
		end
	end

	// Each field below steers the forwarding engine:
	// MLD, IGMP, monitor, VLAN
	assign glb_cfg = glb_q;
	assign tos_prio = tos_prio_q;
	assign cnt_read_load = cnt_load_q;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign pready = 1'b1;

endmodule : spm_regs

`default_nettype wire

// File: spm_regs_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "spm_defines.svh"
module spm_regs_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire spm_pkg::spm_glb_cfg_t glb_cfg,
	input wire logic [31:0] cnt_read_load
);
	import spm_pkg::*;
	wire logic acc = psel && penable;
	wire logic rd = acc && !pwrite;
	wire logic glb = paddr == `SPM_ADDR_GLB_CFG;
	wire logic hit = glb || (paddr >= `SPM_ADDR_CMD &&
		paddr <= `SPM_ADDR_CMD_STS && paddr[1:0] == 2'h0);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_high: assert property (psel |-> pready)
		else $error("pready low in transfer");
	a_glb_write: assert property (
		acc && pwrite && glb |=> glb_cfg == $past(pwdata[17:0]))
		else $error("config write lost");
	a_glb_hold: assert property (
		!(acc && pwrite && glb) |=> $stable(glb_cfg))
		else $error("config changed without write");
	a_glb_read: assert property (rd && glb |-> prdata == {14'h0, glb_cfg})
		else $error("config read wrong");
	a_unmapped_err: assert property (acc && !hit |-> pslverr)
		else $error("no error on unmapped");
	a_mapped_ok: assert property (acc && hit |-> !pslverr)
		else $error("error on mapped");
	a_rdval_rsvd: assert property (
		rd && paddr == `SPM_ADDR_RD_VAL |-> prdata[31:3] == 29'h0)
		else $error("read value reserved bits set");
	a_sts_rsvd: assert property (
		rd && paddr == `SPM_ADDR_CMD_STS |-> prdata[31:1] == 31'h0)
		else $error("status reserved bits set");
	a_cnt_test: assert property ($stable(glb_cfg) |->
		cnt_read_load == (glb_cfg.cnt_test ? 32'h7FFFFFFC : 32'h0))
		else $error("counter load value wrong");
endmodule : spm_regs_props
bind spm_regs spm_regs_props i_spm_regs_props (.pclk, .presetn, .psel,
	.penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .glb_cfg,
	.cnt_read_load);
`default_nettype wire

// File: spm_host.sv
`timescale 1ns/100ps
`default_nettype none
module spm_host (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [15:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial {psel, penable, pwrite, paddr, pwdata} = '0;
	task automatic xfer(input logic w, input logic [15:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		// Released bus shows inverted address and data
		{psel, penable, paddr, pwdata} <= {2'h0, ~a, ~d};
	endtask : xfer
endmodule : spm_host
`default_nettype wire

// File: tb_spm_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "spm_defines.svh"
module tb_spm_regs;
	import spm_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, cnt_read_load, q, w;
	logic [5:0] tos_idx;
	logic [2:0] tos_prio;
	spm_glb_cfg_t glb_cfg;
	int error_cnt, compares;
	spm_regs i_spm_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .glb_cfg, .tos_idx, .tos_prio,
		.cnt_read_load);
	spm_host u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr);
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task automatic chk(input string n, input logic [31:0] s, x);
		compares++;
		if (s !== x) begin
			error_cnt++;
			$display("mismatch %s exp %h seen %h", n, x, s);
		end
	endtask : chk
	task automatic conclude;
		if (error_cnt == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude
	task automatic rd(input logic [15:0] a);
		u_host.xfer(1'b0, a, 32'h0, q, e);
	endtask : rd
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, q, e);
	endtask : wr
	task automatic poll;
		rd(`SPM_ADDR_CMD_STS);
		chk("pending set", q, 32'h1);
		for (int k = 0; k < 8 && q[0] !== 1'b0; k++)
			rd(`SPM_ADDR_CMD_STS);
		chk("pending clear", q, 32'h0);
	endtask : poll
	initial begin
		{presetn, tos_idx, error_cnt, compares} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(`SPM_ADDR_GLB_CFG);
		chk("glb reset", q, 32'h6);
		rd(`SPM_ADDR_WR_VAL);
		chk("wr reset", q, 32'h0);
		for (int i = 0; i < 19; i++) begin
			w = (i < 18) ? 32'h1 << i : 32'hFFFFFFFF;
			wr(`SPM_ADDR_GLB_CFG, w);
			rd(`SPM_ADDR_GLB_CFG);
			chk("glb", q, w & 32'h3FFFF);
			chk("glb port", {14'h0, glb_cfg}, w & 32'h3FFFF);
			chk("cnt", cnt_read_load, w[6] ? 32'h7FFFFFFC : 32'h0);
		end
		for (int i = 0; i < 64; i++) begin
			wr(`SPM_ADDR_WR_VAL, 32'(i % 8) ^ 32'h5);
			wr(`SPM_ADDR_CMD, 32'(i));
			poll;
		end
		for (int i = 63; i >= 0; i--) begin
			wr(`SPM_ADDR_CMD, 32'h80 | 32'(i));
			poll;
			rd(`SPM_ADDR_RD_VAL);
			chk("map read", q, 32'(i % 8) ^ 32'h5);
		end
		for (int i = 0; i < 64; i++) begin
			tos_idx <= 6'(i);
			repeat (3) @(posedge pclk);
			chk("lookup", 32'(tos_prio), 32'(i % 8) ^ 32'h5);
		end
		wr(`SPM_ADDR_RD_VAL, 32'h2);
		rd(`SPM_ADDR_RD_VAL);
		chk("ro keep", q, 32'h5);
		wr(`SPM_ADDR_CMD, 32'h81);
		wr(`SPM_ADDR_CMD, 32'h02);
		rd(`SPM_ADDR_CMD);
		chk("cmd busy refuse", q, 32'h81);
		rd(`SPM_ADDR_RD_VAL);
		chk("map read one", q, 32'h4);
		rd(16'h6054);
		chk("unmapped err", 32'(e), 32'h1);
		chk("unmapped data", q, 32'h0);
		conclude;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		conclude;
	end
endmodule : tb_spm_regs
`default_nettype wire
